// file: src/ptco_consts.svh
/*
  constants for the periodic timer with compare output: register byte
  addresses, field positions, reset values, mode and action codes and
  prescaler tap widths.
  assumes inclusion by bare name from the design file that needs them.
*/
`ifndef PTCO_CONSTS_SVH
`define PTCO_CONSTS_SVH

// ---------------------------------------------------------------------
// register byte addresses (one aligned 32-bit word each)
// ---------------------------------------------------------------------
`define PTCO_ADDR_CTRL_ZERO   8'h00
`define PTCO_ADDR_CTRL_ONE    8'h04
`define PTCO_ADDR_CNT_LO      8'h08
`define PTCO_ADDR_CNT_HI      8'h0c
`define PTCO_ADDR_CMPA_LO     8'h10
`define PTCO_ADDR_CMPA_HI     8'h14
`define PTCO_ADDR_PER_LO      8'h18
`define PTCO_ADDR_PER_HI      8'h1c
`define PTCO_ADDR_FLAGS       8'h20

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define PTCO_C0_PAUSE         7
`define PTCO_C0_CLK_HI        6
`define PTCO_C0_CLK_LO        4
`define PTCO_C0_ENABLE        3
`define PTCO_C1_MODE_HI       7
`define PTCO_C1_MODE_LO       6
`define PTCO_C1_ACT_HI        5
`define PTCO_C1_ACT_LO        4
`define PTCO_C1_INIT          3
`define PTCO_C1_INV           2
`define PTCO_C1_CAPSRC        1
`define PTCO_C1_CLRSRC        0
`define PTCO_FL_A             0
`define PTCO_FL_P             1

// ---------------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------------
`define PTCO_RST_BYTE         8'h00
`define PTCO_RST_CNT          10'h000
`define PTCO_CNT_MAX          10'h3ff
`define PTCO_MODE_CMP         2'h0
`define PTCO_MODE_CAP         2'h1
`define PTCO_MODE_PWM         2'h2
`define PTCO_MODE_TMR         2'h3
`define PTCO_ACT_00           2'h0
`define PTCO_ACT_01           2'h1
`define PTCO_ACT_10           2'h2
`define PTCO_ACT_11           2'h3
`define PTCO_RESP_OKAY        2'h0
`define PTCO_RESP_SLVERR      2'h2

// ---------------------------------------------------------------------
// counting clock taps (prescaler low-bit widths)
// ---------------------------------------------------------------------
`define PTCO_DIV4_BITS        2
`define PTCO_DIV16_BITS       4
`define PTCO_DIV64_BITS       6
`define PTCO_PRE_W            8

`endif

// file: src/ptco_pkg.sv
/*
  types shared by the periodic timer with compare output.
  assumes nothing of its surroundings.
*/
package ptco_pkg;
  typedef logic [9:0] ptco_cnt_t;   // 10-bit counter / compare value
  typedef logic [7:0] ptco_byte_t;  // one register byte
  typedef logic [1:0] ptco_code_t;  // mode or action code
endpackage

// file: src/ptco_timer.sv
/*
  periodic timer with compare output: 10-bit up counter, comparators
  a and p, capture, pwm / single pulse and complementary output pins,
  registers reached over axi4-lite.
  assumes one 25 mhz clock, synchronous active-low reset, pins from
  outside the clock domain and a master that keeps axi valid rules.
*/
// Notes on behaviour
// [RQ1] compare mode action: keep, low, high, toggle
// [RQ2] pwm mode action: inactive, active, pwm, pulse
// [RQ3] capture edge: rising, falling, both, none
// [RQ4] requested level equal initial: no pin change
// [RQ5] enable rising edge restores initial output level
// [RQ6] software changes pwm action only while off
// [RQ7] initial bit: pre-match level or active level
// [RQ8] invert bit inverts pin except timer mode; the code also holds the pin low, uninverted, in capture mode
// [RQ9] capture source: capture pin or clock pin
// [RQ10] clear on a match, or p/overflow
// [RQ11] overflow clears only when period zero
// [RQ12] clear source ignored in pwm, capture
// [RQ13] counter read only, high bits zero
// [RQ14] compare a read/write, resets to zero
// [RQ15] period read/write, resets to zero
// [RQ16] mode 00 selects compare match output
// [RQ17] clear source 0: both flags raised
// [RQ18] clear source 1: only a flag
// [RQ19] compare a zero: overflow, no a flag
// [RQ20] pin changes only on a flag matches
// [RQ21] mode codes: compare, capture, pwm, timer
// [RQ22] enable rise zeroes counter, fall holds it
// [RQ23] pause holds counter, release resumes it
// [RQ24] match when counter reaches compare value
// [RQ25] flags sticky until cleared, request lines
`timescale 1ns/1ps
`include "ptco_consts.svh"

module ptco_timer
  import ptco_pkg::*;
#(
  parameter int TBC_BITS = `PTCO_PRE_W  // tap for the time base clock
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  // axi4-lite write response
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  // axi4-lite read
  input  wire logic [7:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  // pins
  input  wire logic        capture_input_pin_i,
  input  wire logic        external_clock_pin_i,
  output logic             timer_output_pin_o,
  output logic             timer_output_pin_inverted_o,
  // match request lines
  output logic             match_a_flag_o,
  output logic             match_p_flag_o
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  logic                  aw_rdy_r, b_vld_r, ar_rdy_r, r_vld_r;
  logic [1:0]            b_resp_r, r_resp_r;
  logic [31:0]           r_data_r;
  ptco_byte_t            ctrl_one_r;   // timer_control_one
  logic                  pause_r;      // counter_pause
  logic [2:0]            clk_sel_r;    // counting clock select
  logic                  en_r;         // counter_enable
  logic                  en_prev_r;    // enable one cycle ago
  ptco_cnt_t             cnt_r;        // the counter
  ptco_cnt_t             cmp_a_r;      // compare_a_value
  ptco_cnt_t             per_r;        // period_value
  logic                  flag_a_r, flag_p_r;
  logic                  out_lvl_r;    // compare mode output level
  logic                  pin_r, pin_b_r;
  logic [`PTCO_PRE_W-1:0] pre_r;       // prescaler
  logic [2:0]            cap_sync_r;   // two sync flops plus history
  logic [2:0]            ext_sync_r;

  // -------------------------------------------------------------------
  // decoded fields and events
  // -------------------------------------------------------------------
  ptco_code_t mode, act;
  logic       init_lvl, inv, cap_src, clr_src;
  logic       wr_fire, rd_fire, wr_map, rd_map;
  logic       en_rise, tick, run;
  ptco_cnt_t  cnt_nxt;
  logic       a_hit, p_hit, a_clr, p_clr, cnt_clr;
  logic       a_set, p_set, cap_evt, cap_rise, cap_fall;
  logic       ext_rise, ext_fall, pwm_on, pwm_lvl, pin_nxt;
  logic       fl_clr_a, fl_clr_p;
  logic [7:0] wbyte;

  assign mode     = ctrl_one_r[`PTCO_C1_MODE_HI:`PTCO_C1_MODE_LO];
  assign act      = ctrl_one_r[`PTCO_C1_ACT_HI:`PTCO_C1_ACT_LO];
  assign init_lvl = ctrl_one_r[`PTCO_C1_INIT];
  assign inv      = ctrl_one_r[`PTCO_C1_INV];
  assign cap_src  = ctrl_one_r[`PTCO_C1_CAPSRC];
  assign clr_src  = ctrl_one_r[`PTCO_C1_CLRSRC];
  assign wbyte    = s_wdata_i[7:0];

  // -------------------------------------------------------------------
  // axi4-lite slave handshakes
  // -------------------------------------------------------------------
  // write taken in the cycle awready is high with both valids
  assign wr_fire = aw_rdy_r & s_awvalid_i & s_wvalid_i;
  assign rd_fire = ar_rdy_r & s_arvalid_i;

  // write address/data ready, one-cycle pulse, then response
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      aw_rdy_r <= 1'b0;
      b_vld_r  <= 1'b0;
      b_resp_r <= `PTCO_RESP_OKAY;
    end else begin
      aw_rdy_r <= s_awvalid_i & s_wvalid_i & ~aw_rdy_r & ~b_vld_r;
      if (wr_fire) begin
        b_vld_r  <= 1'b1;
        b_resp_r <= wr_map ? `PTCO_RESP_OKAY : `PTCO_RESP_SLVERR;
      end else if (s_bready_i) begin
        b_vld_r <= 1'b0;
      end
    end
  end

  // read address ready pulse, then data one cycle later
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ar_rdy_r <= 1'b0;
      r_vld_r  <= 1'b0;
      r_resp_r <= `PTCO_RESP_OKAY;
      r_data_r <= 32'h0000_0000;
    end else begin
      ar_rdy_r <= s_arvalid_i & ~ar_rdy_r & ~r_vld_r;
      if (rd_fire) begin
        r_vld_r <= 1'b1;
        r_resp_r <= rd_map ? `PTCO_RESP_OKAY : `PTCO_RESP_SLVERR;
        // counter bytes read only, unused bits zero [RQ13]
        case (s_araddr_i)
          `PTCO_ADDR_CTRL_ZERO: r_data_r <= {24'h0, pause_r, clk_sel_r,
                                             en_r, 3'h0};
          `PTCO_ADDR_CTRL_ONE:  r_data_r <= {24'h0, ctrl_one_r};
          `PTCO_ADDR_CNT_LO:    r_data_r <= {24'h0, cnt_r[7:0]};
          `PTCO_ADDR_CNT_HI:    r_data_r <= {30'h0, cnt_r[9:8]};
          `PTCO_ADDR_CMPA_LO:   r_data_r <= {24'h0, cmp_a_r[7:0]};
          `PTCO_ADDR_CMPA_HI:   r_data_r <= {30'h0, cmp_a_r[9:8]};
          `PTCO_ADDR_PER_LO:    r_data_r <= {24'h0, per_r[7:0]};
          `PTCO_ADDR_PER_HI:    r_data_r <= {30'h0, per_r[9:8]};
          `PTCO_ADDR_FLAGS:     r_data_r <= {30'h0, flag_p_r, flag_a_r};
          default:              r_data_r <= 32'h0000_0000;
        endcase
      end else if (s_rready_i) begin
        r_vld_r <= 1'b0;
      end
    end
  end

  // address decode for the response code
  always_comb begin
    wr_map = 1'b1;
    rd_map = 1'b1;
    case (s_awaddr_i)
      `PTCO_ADDR_CTRL_ZERO, `PTCO_ADDR_CTRL_ONE, `PTCO_ADDR_CNT_LO,
      `PTCO_ADDR_CNT_HI, `PTCO_ADDR_CMPA_LO, `PTCO_ADDR_CMPA_HI,
      `PTCO_ADDR_PER_LO, `PTCO_ADDR_PER_HI, `PTCO_ADDR_FLAGS: ;
      default: wr_map = 1'b0;
    endcase
    case (s_araddr_i)
      `PTCO_ADDR_CTRL_ZERO, `PTCO_ADDR_CTRL_ONE, `PTCO_ADDR_CNT_LO,
      `PTCO_ADDR_CNT_HI, `PTCO_ADDR_CMPA_LO, `PTCO_ADDR_CMPA_HI,
      `PTCO_ADDR_PER_LO, `PTCO_ADDR_PER_HI, `PTCO_ADDR_FLAGS: ;
      default: rd_map = 1'b0;
    endcase
  end

  // -------------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------------
  // control one byte: mode, action, initial, invert, sources
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ctrl_one_r <= `PTCO_RST_BYTE;
    end else if (wr_fire && s_wstrb_i[0] &&
                 s_awaddr_i == `PTCO_ADDR_CTRL_ONE) begin
      ctrl_one_r <= wbyte;
    end
  end

  // control zero: pause, clock select, enable
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pause_r   <= 1'b0;
      clk_sel_r <= 3'h0;
      en_r      <= 1'b0;
    end else if (wr_fire && s_wstrb_i[0] &&
                 s_awaddr_i == `PTCO_ADDR_CTRL_ZERO) begin
      pause_r   <= wbyte[`PTCO_C0_PAUSE];
      clk_sel_r <= wbyte[`PTCO_C0_CLK_HI:`PTCO_C0_CLK_LO];
      en_r      <= wbyte[`PTCO_C0_ENABLE];
    end else if (mode == `PTCO_MODE_PWM && act == `PTCO_ACT_11) begin
      // single pulse: a match ends it, clock pin rise starts it
      if (run && a_hit) begin
        en_r <= 1'b0;
      end else if (ext_rise) begin
        en_r <= 1'b1;
      end
    end
  end

  // enable history for edge detection
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      en_prev_r <= 1'b0;
    end else begin
      en_prev_r <= en_r;
    end
  end

  // compare a: software write, or capture latch (capture wins) [RQ14]
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cmp_a_r <= `PTCO_RST_CNT;
    end else if (cap_evt) begin
      cmp_a_r <= cnt_r;
    end else if (wr_fire && s_wstrb_i[0]) begin
      if (s_awaddr_i == `PTCO_ADDR_CMPA_LO) begin
        cmp_a_r[7:0] <= wbyte;
      end else if (s_awaddr_i == `PTCO_ADDR_CMPA_HI) begin
        cmp_a_r[9:8] <= wbyte[1:0];
      end
    end
  end

  // period bytes [RQ15]
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      per_r <= `PTCO_RST_CNT;
    end else if (wr_fire && s_wstrb_i[0]) begin
      if (s_awaddr_i == `PTCO_ADDR_PER_LO) begin
        per_r[7:0] <= wbyte;
      end else if (s_awaddr_i == `PTCO_ADDR_PER_HI) begin
        per_r[9:8] <= wbyte[1:0];
      end
    end
  end

  // -------------------------------------------------------------------
  // pin synchronisers and counting clock
  // -------------------------------------------------------------------
  // two flops, then a third for edge history
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cap_sync_r <= 3'h0;
      ext_sync_r <= 3'h0;
      pre_r      <= '0;
    end else begin
      cap_sync_r <= {cap_sync_r[1:0], capture_input_pin_i};
      ext_sync_r <= {ext_sync_r[1:0], external_clock_pin_i};
      pre_r      <= pre_r + 1'b1;
    end
  end

  assign ext_rise = ext_sync_r[1] & ~ext_sync_r[2];
  assign ext_fall = ~ext_sync_r[1] & ext_sync_r[2];

  // counting clock enable from the selected source
  always_comb begin
    case (clk_sel_r)
      3'h0:    tick = &pre_r[`PTCO_DIV4_BITS-1:0];
      3'h1:    tick = 1'b1;
      3'h2:    tick = &pre_r[`PTCO_DIV16_BITS-1:0];
      3'h3:    tick = &pre_r[`PTCO_DIV64_BITS-1:0];
      3'h4,
      3'h5:    tick = &pre_r[TBC_BITS-1:0];
      3'h6:    tick = ext_rise;
      default: tick = ext_fall;
    endcase
  end

  // -------------------------------------------------------------------
  // comparators and counter
  // -------------------------------------------------------------------
  assign en_rise = en_r & ~en_prev_r;
  assign run     = en_r & ~pause_r & tick;  // pause holds [RQ23]
  assign cnt_nxt = cnt_r + 10'h001;
  // match when the count reaches the value; period 0 is overflow
  assign a_hit   = (cnt_nxt == cmp_a_r) && (cmp_a_r != 10'h000); // [RQ24]
  assign p_hit   = (cnt_nxt == per_r);    // zero only on wrap [RQ11]

  // per-mode clear and flag selection [RQ21]
  always_comb begin
    a_clr = 1'b0;
    p_clr = 1'b0;
    a_set = 1'b0;
    p_set = 1'b0;
    case (mode)
      `PTCO_MODE_CMP, `PTCO_MODE_TMR: begin  // [RQ16]
        a_clr = clr_src;                     // [RQ10]
        p_clr = ~clr_src;
        a_set = run & a_hit;                 // [RQ19]
        p_set = run & p_hit & ~clr_src;      // [RQ17] [RQ18]
      end
      `PTCO_MODE_CAP: begin                  // clear source ignored [RQ12]
        p_clr = 1'b1;
        a_set = cap_evt;
        p_set = run & p_hit;
      end
      `PTCO_MODE_PWM: begin
        p_clr = (act != `PTCO_ACT_11);
        a_set = run & a_hit;
        p_set = run & p_hit & (act != `PTCO_ACT_11);
      end
      default: ;
    endcase
  end
  assign cnt_clr = (a_clr & a_hit) | (p_clr & p_hit);

  // counter: zero on enable rise, hold when off [RQ22]
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cnt_r <= `PTCO_RST_CNT;
    end else if (en_rise) begin
      cnt_r <= `PTCO_RST_CNT;
    end else if (run) begin
      cnt_r <= cnt_clr ? `PTCO_RST_CNT : cnt_nxt;
    end
  end

  // -------------------------------------------------------------------
  // capture
  // -------------------------------------------------------------------
  // source pin select [RQ9]
  assign cap_rise = cap_src ? ext_rise
                            : (cap_sync_r[1] & ~cap_sync_r[2]);
  assign cap_fall = cap_src ? ext_fall
                            : (~cap_sync_r[1] & cap_sync_r[2]);

  // edge select, 11 disables capture [RQ3]
  always_comb begin
    cap_evt = 1'b0;
    if (mode == `PTCO_MODE_CAP && en_r) begin
      case (act)
        `PTCO_ACT_00: cap_evt = cap_rise;
        `PTCO_ACT_01: cap_evt = cap_fall;
        `PTCO_ACT_10: cap_evt = cap_rise | cap_fall;
        default:      cap_evt = 1'b0;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // match flags: sticky, write one to clear, set wins [RQ25]
  // -------------------------------------------------------------------
  assign fl_clr_a = wr_fire & s_wstrb_i[0] &
                    (s_awaddr_i == `PTCO_ADDR_FLAGS) & wbyte[`PTCO_FL_A];
  assign fl_clr_p = wr_fire & s_wstrb_i[0] &
                    (s_awaddr_i == `PTCO_ADDR_FLAGS) & wbyte[`PTCO_FL_P];

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end else begin
      flag_a_r <= a_set | (flag_a_r & ~fl_clr_a);
      flag_p_r <= p_set | (flag_p_r & ~fl_clr_p);
    end
  end

  // -------------------------------------------------------------------
  // output generation
  // -------------------------------------------------------------------
  // compare mode level: initial on enable rise, action on a match
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      out_lvl_r <= 1'b0;
    end else if (en_rise) begin
      out_lvl_r <= init_lvl;                // [RQ5] [RQ7]
    end else if (mode == `PTCO_MODE_CMP && a_set) begin  // [RQ20]
      case (act)                            // [RQ1] [RQ4]
        `PTCO_ACT_01: out_lvl_r <= 1'b0;
        `PTCO_ACT_10: out_lvl_r <= 1'b1;
        `PTCO_ACT_11: out_lvl_r <= ~out_lvl_r;
        default:      out_lvl_r <= out_lvl_r;
      endcase
    end
  end

  // pwm / single pulse level; initial bit is the active level
  assign pwm_on = (cmp_a_r >= per_r && per_r != 10'h000) ||
                  (cnt_r < cmp_a_r);
  always_comb begin
    case (act)                              // [RQ2] [RQ6]
      `PTCO_ACT_00: pwm_lvl = ~init_lvl;
      `PTCO_ACT_01: pwm_lvl = init_lvl;
      `PTCO_ACT_10: pwm_lvl = pwm_on ? init_lvl : ~init_lvl;
      default:      pwm_lvl = en_r ? init_lvl : ~init_lvl;
    endcase
  end

  // pin level; timer and capture modes hold the pin low, inverted pin high [RQ8]
  always_comb begin
    case (mode)
      `PTCO_MODE_CMP: pin_nxt = out_lvl_r ^ inv;
      `PTCO_MODE_PWM: pin_nxt = pwm_lvl ^ inv;
      default:        pin_nxt = 1'b0;
    endcase
  end

  // registered complementary pins
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pin_r   <= 1'b0;
      pin_b_r <= 1'b1;
    end else begin
      pin_r   <= pin_nxt;
      pin_b_r <= ~pin_nxt;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign s_awready_o = aw_rdy_r;
  assign s_wready_o  = aw_rdy_r;
  assign s_bvalid_o  = b_vld_r;
  assign s_bresp_o   = b_resp_r;
  assign s_arready_o = ar_rdy_r;
  assign s_rvalid_o  = r_vld_r;
  assign s_rresp_o   = r_resp_r;
  assign s_rdata_o   = r_data_r;
  assign timer_output_pin_o          = pin_r;
  assign timer_output_pin_inverted_o = pin_b_r;
  assign match_a_flag_o = flag_a_r;
  assign match_p_flag_o = flag_p_r;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence seq_en_up;
    $rose(en_r);
  endsequence
  sequence seq_cnt_zero;
    cnt_r == `PTCO_RST_CNT;
  endsequence

  chk_restart_zero: assert property (seq_en_up |=> seq_cnt_zero) // [RQ22]
    else $error("counter not zero after enable rise");
  chk_off_hold: assert property (!en_r |=> $stable(cnt_r)) // [RQ22]
    else $error("counter moved while disabled");
  chk_pause_hold: assert property (
    en_r && en_prev_r && pause_r |=> $stable(cnt_r)) // [RQ23]
    else $error("counter moved while paused");
  chk_out_init: assert property (
    seq_en_up |=> out_lvl_r == $past(init_lvl)) // [RQ5]
    else $error("output not at initial level");
  chk_flag_sticky: assert property (
    flag_a_r && !fl_clr_a |=> flag_a_r) // [RQ25]
    else $error("a flag lost without clear");
  chk_no_p_flag: assert property (
    $rose(flag_p_r) |-> !$past(mode == `PTCO_MODE_CMP && clr_src)) // [RQ18]
    else $error("p flag with a-clear selected");
  chk_zero_cmpa: assert property (
    mode == `PTCO_MODE_CMP && cmp_a_r == 10'h000 && !flag_a_r
    |=> !flag_a_r) // [RQ19]
    else $error("a flag with compare a zero");
  chk_ovf_wrap: assert property (
    run && !en_rise && mode == `PTCO_MODE_CMP && !clr_src &&
    per_r == 10'h000 && cnt_r == `PTCO_CNT_MAX |=> seq_cnt_zero) // [RQ11]
    else $error("no wrap at overflow");
  chk_toggle_out: assert property (
    mode == `PTCO_MODE_CMP && a_set && !en_rise && act == `PTCO_ACT_11
    |=> out_lvl_r != $past(out_lvl_r) ##1 pin_r == (out_lvl_r ^ inv)) // [RQ1]
    else $error("toggle missed");
  chk_pin_tmr: assert property (
    mode == `PTCO_MODE_TMR |=> !pin_r && pin_b_r) // [RQ8]
    else $error("pin driven in timer mode");
  chk_hi_zero: assert property (
    r_vld_r && $past(rd_fire) && $past(s_araddr_i) == `PTCO_ADDR_CNT_HI
    |-> r_data_r[31:2] == 30'h0) // [RQ13]
    else $error("counter high byte upper bits set");

endmodule

// file: sim/ptco_pin_model.sv
/*
  pin model: capture and clock sources on the timer input pins, and a
  load on the complementary output pair.
  assumes the bench asks for the source levels.
*/
`timescale 1ns/1ps
module ptco_pin_model (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic resetn_i,
  // requested source levels
  input  wire logic cap_req_i,
  input  wire logic ck_req_i,
  // pins
  output logic      capture_input_pin_o = 1'b0,
  output logic      external_clock_pin_o = 1'b0,
  input  wire logic timer_output_pin_i,
  input  wire logic timer_output_pin_inverted_i,
  // load status
  output logic      bad_o = 1'b0
);
  // sources move away from the sampling edge
  always @(negedge clock_i) begin
    capture_input_pin_o <= cap_req_i;
    external_clock_pin_o <= ck_req_i;
  end
  // load marks any cycle where the pair is not complementary
  always @(posedge clock_i) begin
    if (!resetn_i) begin
      bad_o <= 1'b0;
    end else if (timer_output_pin_i === timer_output_pin_inverted_i) begin
      bad_o <= 1'b1;
    end
  end
endmodule

// file: sim/tb_top.sv
/*
  bench for ptco_timer: register table, then compare, capture, pause
  and reset cases. assumes ptco_pin_model on the pins.
*/
`timescale 1ns/1ps
module tb_top import ptco_pkg::*;;
  // ----
  // signals
  // ----
  logic        clock_i = 0, resetn_i = 0, cap_req = 0, ck_req = 0, bad, lv;
  logic [7:0]  s_awaddr_i = '0, s_araddr_i = '0;
  logic [31:0] s_wdata_i = '0, s_rdata_o;
  logic [3:0]  s_wstrb_i = 4'h1;
  logic        s_awvalid_i = 0, s_wvalid_i = 0, s_bready_i = 0;
  logic        s_arvalid_i = 0, s_rready_i = 0, s_awready_o;
  logic        s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic [1:0]  s_bresp_o, s_rresp_o, rsp;
  logic        capture_input_pin_i, external_clock_pin_i;
  logic        timer_output_pin_o, timer_output_pin_inverted_o;
  logic        match_a_flag_o, match_p_flag_o;
  ptco_byte_t  v, v2, c1;
  logic [23:0] rows [7];
  logic [7:0]  cp [4];
  logic [8:0]  pw [4];
  int          fails = 0, n_checks = 0, k;

  ptco_timer #(.TBC_BITS(4)) ptco_timer_inst (.*);
  ptco_pin_model ptco_pin_model_inst (.clock_i(clock_i),
    .resetn_i(resetn_i), .cap_req_i(cap_req), .ck_req_i(ck_req),
    .capture_input_pin_o(capture_input_pin_i),
    .external_clock_pin_o(external_clock_pin_i),
    .timer_output_pin_i(timer_output_pin_o),
    .timer_output_pin_inverted_i(timer_output_pin_inverted_o),
    .bad_o(bad));

  always #20 clock_i = ~clock_i;

  task automatic cyc(int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  // axi4-lite write, holds each valid until its ready
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock_i);
    s_awaddr_i <= a;
    s_wdata_i <= {24'h0, d};
    s_awvalid_i <= 1;
    s_wvalid_i <= 1;
    s_bready_i <= 1;
    do @(posedge clock_i); while (s_awready_o !== 1'b1);
    s_awvalid_i <= 0;
    s_wvalid_i <= 0;
    do @(posedge clock_i); while (s_bvalid_o !== 1'b1);
    rsp = s_bresp_o;
    s_bready_i <= 0;
  endtask
  task automatic rd(logic [7:0] a, output ptco_byte_t d);
    @(posedge clock_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1;
    s_rready_i <= 1;
    do @(posedge clock_i); while (s_arready_o !== 1'b1);
    s_arvalid_i <= 0;
    do @(posedge clock_i); while (s_rvalid_o !== 1'b1);
    d = s_rdata_o[7:0];
    rsp = s_rresp_o;
    s_rready_i <= 0;
  endtask
  task automatic wflag(logic p);
    for (int i = 0; i < 3000; i++)
      if ((p ? match_p_flag_o : match_a_flag_o) !== 1'b1) cyc(1);
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // watchdog, far above the few thousand cycles needed
  initial begin
    cyc(20000);
    fails++;
    complete_run();
  end

  initial begin
    rows = '{24'h10a5a5, 24'h14ff03, 24'h185a5a, 24'h1cfe02,
             24'h087700, 24'h0cff00, 24'h043131};
    cp = '{8'h40, 8'h70, 8'h42, 8'h42};
    cyc(20);
    resetn_i <= 1;
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], v);
      chk("reg", v, rows[i][7:0]);
    end
    wr(8'h24, 8'h55);
    chk("bresp", rsp, 2'h2);
    rd(8'h24, v);
    chk("rresp", rsp, 2'h2);
    // byte strobe low stores nothing
    s_wstrb_i <= 4'h0;
    wr(8'h10, 8'h00);
    s_wstrb_i <= 4'h1;
    rd(8'h10, v);
    chk("strb", v, 8'ha5);
    // second reset in mid-run clears every register of the table
    resetn_i <= 0;
    cyc(2);
    resetn_i <= 1;
    foreach (rows[i]) begin
      rd(rows[i][23:16], v);
      chk("rst", v, 8'h00);
    end
    // every action, initial level and invert in compare mode
    wr(8'h10, 8'h40);
    for (k = 0; k < 16; k++) begin
      c1 = {2'b00, k[1:0], k[2], k[3], 2'b01};
      wr(8'h00, 8'h10); // action changed only while off
      wr(8'h04, c1);
      wr(8'h00, 8'h18);
      cyc(2);
      chk("init", timer_output_pin_o, k[2] ^ k[3]);
      wflag(0);
      cyc(3);
      wr(8'h00, 8'h10);
      lv = (k[1:0] == 0) ? k[2] : (k[1:0] == 3) ? !k[2] : k[1];
      chk("pin", timer_output_pin_o, lv ^ k[3]);
      rd(8'h20, v);
      chk("flg", v, 8'h01);
      chk("line", {match_p_flag_o, match_a_flag_o}, 2'h1);
      wr(8'h20, 8'h03);
    end
    rd(8'h20, v);
    chk("clr", v, 8'h00);
    // clear on period: both flags, counter stays below period
    wr(8'h10, 8'h10);
    wr(8'h18, 8'h20);
    wr(8'h04, 8'h30);
    wr(8'h00, 8'h18);
    wflag(1);
    cyc(3);
    rd(8'h20, v);
    chk("both", v, 8'h03);
    rd(8'h08, v);
    chk("wrap", v < 8'h20, 1);
    wr(8'h00, 8'h98);
    rd(8'h08, v);
    rd(8'h08, v2);
    chk("pause", v2, v);
    wr(8'h00, 8'h10);
    rd(8'h08, v);
    cyc(20);
    rd(8'h08, v2);
    chk("hold", v2, v);
    wr(8'h00, 8'h18);
    rd(8'h08, v);
    chk("zero", v < 8'h0a, 1);
    // compare a at zero: overflow at 3ff raises p only, no a flag
    wr(8'h00, 8'h10);
    wr(8'h10, 8'h00);
    wr(8'h18, 8'h00);
    wr(8'h20, 8'h03);
    wr(8'h04, 8'h30);
    wr(8'h00, 8'h18);
    cyc(1100);
    rd(8'h20, v);
    chk("nof", v, 8'h02);
    // capture: rising on capture pin, disabled, clock pin source
    for (k = 0; k < 4; k++) begin
      wr(8'h00, 8'h10);
      wr(8'h10, 8'h00);
      wr(8'h04, cp[k]);
      wr(8'h00, 8'h18);
      cyc(30);
      cap_req <= (k != 3);
      ck_req <= (k == 3);
      cyc(10);
      cap_req <= 0;
      ck_req <= 0;
      rd(8'h10, v);
      chk("cap", v != 0, k == 0 || k == 3);
    end
    // forced pwm levels, then timer mode; action set while off
    pw = '{9'h110, 9'h131, 9'h138, 9'h188};
    wr(8'h00, 8'h10);
    foreach (pw[i]) begin
      wr(8'h04, pw[i][8:1]);
      cyc(2);
      chk("pwm", timer_output_pin_o, pw[i][0]);
    end
    chk("pair", bad, 1'b0);
    complete_run();
  end
endmodule
